/* File: src/cbsr_defines.vh */
// Constants for the clock buffer SMBus configuration register bank.
// Assumes inclusion by bare name from the design files of the block that use its constants.
`ifndef CBSR_DEFINES_VH
`define CBSR_DEFINES_VH

// ==========================================================================
// Register indices.
`define CBSR_IDX_EN_SWING   8'h01
`define CBSR_IDX_EDGE_0_3   8'h02
`define CBSR_IDX_EDGE_4     8'h03
`define CBSR_IDX_RSVD_ONES  8'h04
`define CBSR_IDX_REV_MAKER  8'h05
`define CBSR_IDX_PART       8'h06
`define CBSR_IDX_RB_LEN     8'h07

// ==========================================================================
// Reset values and masks of writable bytes (mask marks read/write bits), and fixed read values.
`define CBSR_RST_EN_SWING   8'h6c
`define CBSR_MSK_EN_SWING   8'h23
`define CBSR_RST_EDGE_0_3   8'hff
`define CBSR_MSK_EDGE_0_3   8'h6a
`define CBSR_RST_EDGE_4     8'h01
`define CBSR_MSK_EDGE_4     8'h01
`define CBSR_RST_RB_LEN     8'h08
`define CBSR_MSK_RB_LEN     8'h1f
`define CBSR_RSVD_VALUE     8'hff
`define CBSR_UNMAPPED_VALUE 8'h00

// ==========================================================================
// Field positions.
`define CBSR_BIT_OUT4_EN    5
`define CBSR_SWING_HI       1
`define CBSR_SWING_LO       0
`define CBSR_BIT_EDGE0      1
`define CBSR_BIT_EDGE1      3
`define CBSR_BIT_EDGE2      5
`define CBSR_BIT_EDGE3      6
`define CBSR_BIT_EDGE4      0

// ==========================================================================
// SMBus address prefix; the select pin picks one of three tails.
`define CBSR_ADDR_SEL_LOW   7'h6b
`define CBSR_ADDR_SEL_MID   7'h6c
`define CBSR_ADDR_SEL_HIGH  7'h6d

`endif

/* File: src/cbsr_sync2.v */
// Two-flop synchroniser for one level from outside the core clock domain.
// Assumes the input may change at any time relative to core_clk.
`timescale 1ns/1ps

module cbsr_sync2 #(
  parameter RESET_VALUE = 1'b1
) (
  // Clock and reset.
  input  wire core_clk,
  input  wire reset,
  // Level in and out.
  input  wire async_in,
  output reg  sync_out
);

  // First stage, read only by the second stage.
  reg meta_reg;

  // Two flops in series; the output stage alone is seen by logic.
  always @(posedge core_clk) begin
    if (reset) begin
      meta_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // cbsr_sync2

/* File: src/cbsr_regfile.v */
// Register storage of the configuration bank with a registered read port.
// Assumes single-cycle write strobes from the SMBus engine on core_clk.
`timescale 1ns/1ps
`include "cbsr_defines.vh"

module cbsr_regfile (
  // Clock and reset.
  input  wire       core_clk,
  input  wire       reset,
  // Write port.
  input  wire       wr_en,
  input  wire [7:0] wr_idx,
  input  wire [7:0] wr_data,
  // Read port, data valid the cycle after the index.
  input  wire [7:0] rd_idx,
  output reg  [7:0] rd_data,
  // Fixed identity values.
  input  wire [7:0] id_rev_maker,
  input  wire [7:0] id_part,
  // Stored configuration.
  output reg  [7:0] en_swing_reg,
  output reg  [7:0] edge_0_3_reg,
  output reg  [7:0] edge_4_reg,
  output reg  [7:0] rb_len_reg
);

  // Writable bytes merge new data only at read/write bit positions.
  always @(posedge core_clk) begin
    if (reset) begin
      en_swing_reg <= `CBSR_RST_EN_SWING;
      edge_0_3_reg <= `CBSR_RST_EDGE_0_3;
      edge_4_reg   <= `CBSR_RST_EDGE_4;
      rb_len_reg   <= `CBSR_RST_RB_LEN;
    end else if (wr_en) begin
      case (wr_idx)
        `CBSR_IDX_EN_SWING: begin
          en_swing_reg <= (en_swing_reg & ~`CBSR_MSK_EN_SWING) | (wr_data & `CBSR_MSK_EN_SWING);
        end
        `CBSR_IDX_EDGE_0_3: begin
          edge_0_3_reg <= (edge_0_3_reg & ~`CBSR_MSK_EDGE_0_3) | (wr_data & `CBSR_MSK_EDGE_0_3);
        end
        `CBSR_IDX_EDGE_4: begin
          edge_4_reg <= (edge_4_reg & ~`CBSR_MSK_EDGE_4) | (wr_data & `CBSR_MSK_EDGE_4);
        end
        `CBSR_IDX_RB_LEN: begin
          rb_len_reg <= (rb_len_reg & ~`CBSR_MSK_RB_LEN) | (wr_data & `CBSR_MSK_RB_LEN);
        end
        // Identity, reserved and unmapped bytes ignore writes.
        default: begin
          rb_len_reg <= rb_len_reg;
        end
      endcase
    end
  end

  // Registered read mux.
  always @(posedge core_clk) begin
    if (reset) begin
      rd_data <= `CBSR_UNMAPPED_VALUE;
    end else begin
      case (rd_idx)
        `CBSR_IDX_EN_SWING:  rd_data <= en_swing_reg;
        `CBSR_IDX_EDGE_0_3:  rd_data <= edge_0_3_reg;
        `CBSR_IDX_EDGE_4:    rd_data <= edge_4_reg;
        `CBSR_IDX_RSVD_ONES: rd_data <= `CBSR_RSVD_VALUE;
        `CBSR_IDX_REV_MAKER: rd_data <= id_rev_maker;
        `CBSR_IDX_PART:      rd_data <= id_part;
        `CBSR_IDX_RB_LEN:    rd_data <= rb_len_reg;
        default:             rd_data <= `CBSR_UNMAPPED_VALUE;
      endcase
    end
  end

endmodule // cbsr_regfile

/* File: src/cbsr_top.v */
// SMBus slave and configuration register bank of a differential clock buffer.
// Assumes SMBus clock and data arrive as asynchronous pins with open drain data,
// and that the SMBus clock is at least eight times slower than core_clk.
//
// Summary of operation
// - Cleared enable bit forces output pair low.
// - Byte 1 bits 1:0 choose output swing.
// - Per-output edge speed bits, default fast.
// - Byte 4 always reads all ones.
// - Byte 5 read-only revision and maker code.
// - Byte 6 read-only class and part number.
// - Output 4 enable in byte 1 bit 5.
// - Block read returns count then data.
// - Slave address latched from select pin.
`timescale 1ns/1ps
`include "cbsr_defines.vh"

module cbsr_top #(
  parameter [3:0] SILICON_REV = 4'h3,  // Arbitrary value.
  parameter [3:0] MAKER_CODE  = 4'h9,  // Arbitrary value.
  parameter [1:0] PART_CLASS  = 2'h2,  // Arbitrary value.
  parameter [5:0] PART_NUMBER = 6'h2a  // Arbitrary value.
) (
  // Clock and reset.
  input  wire       core_clk,
  input  wire       reset,
  // SMBus pins.
  input  wire       smb_clk_in,
  input  wire       smb_data_in,
  output reg        smb_data_out,
  output reg        smb_data_oe,
  // Three-level address select pin, decoded as low, mid, high.
  input  wire       addr_sel_low,
  input  wire       addr_sel_high,
  // Output 4 enable pin, active low.
  input  wire       out4_enable_n,
  // Control to the output stage.
  output reg        out4_drive,
  output reg  [1:0] swing_sel,
  output reg  [4:0] edge_speed
);

  // ========================================================================
  // Protocol states, one-hot.
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_ADDR  = 7'h02;
  localparam [6:0] ST_ACK   = 7'h04;
  localparam [6:0] ST_RXB   = 7'h08;
  localparam [6:0] ST_TXB   = 7'h10;
  localparam [6:0] ST_MACK  = 7'h20;
  localparam [6:0] ST_WAIT  = 7'h40;

  // Byte phase of a transaction.
  localparam [1:0] PH_INDEX = 2'h0;
  localparam [1:0] PH_COUNT = 2'h1;
  localparam [1:0] PH_DATA  = 2'h2;

  // ========================================================================
  // Synchronised pins.
  wire       scl_s;           // SMBus clock after two flops.
  wire       sda_s;           // SMBus data after two flops.
  wire       sel_low_s;       // Address select low after two flops.
  wire       sel_high_s;      // Address select high after two flops.
  wire       oe4_n_s;         // Output 4 enable pin after two flops.

  cbsr_sync2 #(.RESET_VALUE(1'b1)) u_sync_scl (
    .core_clk (core_clk), .reset (reset), .async_in (smb_clk_in), .sync_out (scl_s));
  cbsr_sync2 #(.RESET_VALUE(1'b1)) u_sync_sda (
    .core_clk (core_clk), .reset (reset), .async_in (smb_data_in), .sync_out (sda_s));
  cbsr_sync2 #(.RESET_VALUE(1'b0)) u_sync_sl (
    .core_clk (core_clk), .reset (reset), .async_in (addr_sel_low), .sync_out (sel_low_s));
  cbsr_sync2 #(.RESET_VALUE(1'b0)) u_sync_sh (
    .core_clk (core_clk), .reset (reset), .async_in (addr_sel_high), .sync_out (sel_high_s));
  cbsr_sync2 #(.RESET_VALUE(1'b1)) u_sync_oe (
    .core_clk (core_clk), .reset (reset), .async_in (out4_enable_n), .sync_out (oe4_n_s));

  // ========================================================================
  // Edge and condition detection on the synchronised bus.
  reg        scl_d_reg;       // Previous SMBus clock sample.
  reg        sda_d_reg;       // Previous SMBus data sample.
  wire       scl_rise = scl_s & ~scl_d_reg;
  wire       scl_fall = ~scl_s & scl_d_reg;
  wire       start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire       stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  always @(posedge core_clk) begin
    if (reset) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // ========================================================================
  // Slave address captured once after reset release.
  reg        addr_caught_reg; // Address has been latched.
  reg  [6:0] slave_addr_reg;  // Latched slave address.
  reg  [1:0] sel_fill_reg;    // Marks shifted in while the synchronisers refill.

  // The synchronisers still show their reset level for two edges after release, so the
  // pin is sampled once, only when a mark has reached the top of sel_fill_reg.
  always @(posedge core_clk) begin
    if (reset) begin
      addr_caught_reg <= 1'b0;
      slave_addr_reg  <= `CBSR_ADDR_SEL_MID;
      sel_fill_reg    <= 2'h0;
    end else begin
      sel_fill_reg <= {sel_fill_reg[0], 1'b1};
      if (!addr_caught_reg && sel_fill_reg[1]) begin
        addr_caught_reg <= 1'b1;
        if (sel_low_s) begin
          slave_addr_reg <= `CBSR_ADDR_SEL_LOW;
        end else if (sel_high_s) begin
          slave_addr_reg <= `CBSR_ADDR_SEL_HIGH;
        end else begin
          slave_addr_reg <= `CBSR_ADDR_SEL_MID;
        end
      end
    end
  end

  // ========================================================================
  // Protocol engine state.
  reg  [6:0] state_reg;       // Current protocol state.
  reg  [2:0] bit_cnt_reg;     // Bit position within a byte.
  reg  [7:0] shift_reg;       // Receive or transmit shift register.
  reg  [1:0] phase_reg;       // Which byte of the write is expected.
  reg        is_read_reg;     // Current addressed phase is a read.
  reg  [7:0] index_reg;       // Current register index.
  reg  [7:0] remain_reg;      // Data bytes left in the transfer.
  reg        first_tx_reg;    // Byte now being transmitted is the count.
  reg        wr_en_reg;       // Write strobe to the register file.
  reg        nack_mode_reg;   // Next read byte is to be loaded in ST_WAIT.
  wire [7:0] rd_data;         // Registered read data.
  wire [7:0] en_swing_reg;
  wire [7:0] edge_0_3_reg;
  wire [7:0] edge_4_reg;
  wire [7:0] rb_len_reg;

  cbsr_regfile u_regs (
    .core_clk     (core_clk),
    .reset        (reset),
    .wr_en        (wr_en_reg),
    .wr_idx       (index_reg),
    .wr_data      (shift_reg),
    .rd_idx       (index_reg),
    .rd_data      (rd_data),
    .id_rev_maker ({SILICON_REV, MAKER_CODE}),
    .id_part      ({PART_CLASS, PART_NUMBER}),
    .en_swing_reg (en_swing_reg),
    .edge_0_3_reg (edge_0_3_reg),
    .edge_4_reg   (edge_4_reg),
    .rb_len_reg   (rb_len_reg)
  );

  // Bit-level engine: samples data on clock rise, drives data after clock fall.
  always @(posedge core_clk) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 3'h7;
      shift_reg     <= 8'h00;
      phase_reg     <= PH_INDEX;
      is_read_reg   <= 1'b0;
      index_reg     <= 8'h00;
      remain_reg    <= 8'h00;
      first_tx_reg  <= 1'b0;
      wr_en_reg     <= 1'b0;
      nack_mode_reg <= 1'b0;
      smb_data_out  <= 1'b1;
      smb_data_oe   <= 1'b0;
    end else begin
      wr_en_reg <= 1'b0;
      if (stop_c) begin
        // Stop frees the bus in any state.
        state_reg   <= ST_IDLE;
        smb_data_oe <= 1'b0;
      end else if (start_c) begin
        // Start or repeated start; the index is kept across a repeated start.
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 3'h7;
        smb_data_oe <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            smb_data_oe <= 1'b0;
          end
          // Shift in address or a received byte.
          ST_ADDR, ST_RXB: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg - 3'h1;
              if (bit_cnt_reg == 3'h0) begin
                state_reg <= ST_ACK;
              end
            end
          end
          // Acknowledge phase of a received byte.
          ST_ACK: begin
            if (scl_fall && !smb_data_oe) begin
              if (state_reg == ST_ACK && bit_cnt_reg == 3'h7 && phase_reg != 2'h3) begin
                nack_mode_reg <= 1'b0;
              end
              smb_data_oe  <= 1'b1;
              smb_data_out <= 1'b0;
            end else if (scl_fall && smb_data_oe) begin
              // Ack bit done; decide the next byte.
              smb_data_oe <= 1'b0;
              state_reg   <= ST_RXB;
              if (is_read_reg) begin
                state_reg    <= ST_TXB;
                shift_reg    <= {3'h0, rb_len_reg[4:0]};
                remain_reg   <= {3'h0, rb_len_reg[4:0]};
                first_tx_reg <= 1'b1;
                smb_data_oe  <= 1'b1;
                smb_data_out <= 1'b0;
              end
            end
          end
          // Drive a byte out, MSB first.
          ST_TXB: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 3'h0) begin
                bit_cnt_reg <= 3'h7;
                smb_data_oe <= 1'b0;
                state_reg   <= ST_MACK;
              end else begin
                bit_cnt_reg <= bit_cnt_reg - 3'h1;
                shift_reg   <= {shift_reg[6:0], 1'b0};
              end
            end
            smb_data_oe  <= (scl_fall && bit_cnt_reg == 3'h0) ? 1'b0 : ~shift_reg[7];
            smb_data_out <= 1'b0;
          end
          // Host acknowledges; a not-acknowledge ends the read.
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_s || remain_reg == 8'h00) begin
                state_reg <= ST_WAIT;
              end else begin
                state_reg <= ST_WAIT;
                if (!first_tx_reg) begin
                  index_reg <= index_reg + 8'h01;
                end
                first_tx_reg <= 1'b0;
                remain_reg   <= remain_reg - 8'h01;
                shift_reg    <= 8'h00;
                phase_reg    <= PH_DATA;
                is_read_reg  <= 1'b1;
                nack_mode_reg <= 1'b1;
              end
            end
          end
          // Load read data registered one cycle after the index moved.
          ST_WAIT: begin
            if (nack_mode_reg && scl_fall) begin
              nack_mode_reg <= 1'b0;
              shift_reg     <= rd_data;
              state_reg     <= ST_TXB;
              smb_data_oe   <= ~rd_data[7];
              smb_data_out  <= 1'b0;
            end else if (!nack_mode_reg) begin
              smb_data_oe <= 1'b0;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
        // Byte completion for address and written bytes.
        if ((state_reg == ST_ADDR || state_reg == ST_RXB) && scl_rise && bit_cnt_reg == 3'h0) begin
          if (state_reg == ST_ADDR) begin
            if (shift_reg[6:0] != slave_addr_reg) begin
              state_reg <= ST_IDLE;                // Not our address; ignore.
            end else begin
              is_read_reg <= sda_s;
              phase_reg   <= PH_INDEX;
            end
          end else begin
            case (phase_reg)
              PH_INDEX: begin
                index_reg <= {shift_reg[6:0], sda_s};
                phase_reg <= PH_COUNT;
              end
              PH_COUNT: begin
                remain_reg <= {shift_reg[6:0], sda_s};
                phase_reg  <= PH_DATA;
              end
              PH_DATA: begin
                if (remain_reg != 8'h00) begin
                  wr_en_reg  <= 1'b1;
                  remain_reg <= remain_reg - 8'h01;
                end
              end
              default: begin
                phase_reg <= PH_DATA;
              end
            endcase
          end
        end
        // Index advances after each written data byte.
        if (wr_en_reg) begin
          index_reg <= index_reg + 8'h01;
          shift_reg <= 8'h00;
        end
      end
    end
  end

  // ========================================================================
  // Output control, registered from configuration and the enable pin.
  always @(posedge core_clk) begin
    if (reset) begin
      out4_drive <= 1'b0;
      swing_sel  <= 2'h0;
      edge_speed <= 5'h1f;
    end else begin
      out4_drive <= en_swing_reg[`CBSR_BIT_OUT4_EN] & ~oe4_n_s;
      swing_sel  <= en_swing_reg[`CBSR_SWING_HI:`CBSR_SWING_LO];
      edge_speed <= {edge_4_reg[`CBSR_BIT_EDGE4], edge_0_3_reg[`CBSR_BIT_EDGE3],
                     edge_0_3_reg[`CBSR_BIT_EDGE2], edge_0_3_reg[`CBSR_BIT_EDGE1],
                     edge_0_3_reg[`CBSR_BIT_EDGE0]};
    end
  end

endmodule // cbsr_top

/* File: dv/cbsr_top_asserts.sv */
// Checker of the configuration bank pins, bound onto the design top.
// Assumes an SMBus clock far slower than core_clk and a pulled-up data wire.
`timescale 1ns/1ps

module cbsr_top_asserts (
  // Clock and reset.
  input logic       core_clk,
  input logic       reset,
  // SMBus pins.
  input logic       smb_clk_in,
  input logic       smb_data_in,
  input logic       smb_data_out,
  input logic       smb_data_oe,
  // Board pins.
  input logic       addr_sel_low,
  input logic       addr_sel_high,
  input logic       out4_enable_n,
  // Output stage controls.
  input logic       out4_drive,
  input logic [1:0] swing_sel,
  input logic [4:0] edge_speed
);
  // ==========================================================================
  // Idle detection.
  logic [4:0] hi_cnt;  // Cycles the bus clock has stayed high, saturating.

  // Counts clock-high cycles; a bit slot never stays high past twelve.
  always_ff @(posedge core_clk) begin
    if (reset || !smb_clk_in) begin
      hi_cnt <= 5'h00;
    end else if (hi_cnt != 5'h1f) begin
      hi_cnt <= hi_cnt + 5'h01;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Properties.
  property p_reset_vals;
    disable iff (1'b0) $fell(reset) |-> !smb_data_oe && !out4_drive && swing_sel == 2'h0 && edge_speed == 5'h1f;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Outputs differ from defaults after reset.");
  property p_open_drain;
    smb_data_oe |-> !smb_data_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("Data driven high.");
  property p_oe_clk_low;
    $changed(smb_data_oe) |-> !smb_clk_in;
  endproperty
  a_oe_clk_low: assert property (p_oe_clk_low)
    else $error("Data changed while bus clock high.");
  property p_idle_release;
    hi_cnt > 5'h0c |-> !smb_data_oe;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("Data held low on an idle bus.");
  property p_idle_stable;
    hi_cnt > 5'h0c |-> $stable(swing_sel) && $stable(edge_speed);
  endproperty
  a_idle_stable: assert property (p_idle_stable)
    else $error("Configuration moved without bus traffic.");
  property p_pin_off;
    out4_enable_n [*5] |=> !out4_drive;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("Output 4 runs with its pin inactive.");
  property p_pin_on;
    $rose(out4_drive) |-> !$past(out4_enable_n, 2) || !$past(out4_enable_n, 3) || !$past(out4_enable_n, 4);
  endproperty
  a_pin_on: assert property (p_pin_on)
    else $error("Output 4 started without its pin active.");
  property p_oe_min;
    $rose(smb_data_oe) |-> smb_data_oe [*8];
  endproperty
  a_oe_min: assert property (p_oe_min)
    else $error("Driven bit too short.");
  property p_oe_max;
    $rose(smb_data_oe) |-> ##[1:200] !smb_data_oe;
  endproperty
  a_oe_max: assert property (p_oe_max)
    else $error("Data held low too long.");
endmodule // cbsr_top_asserts

bind cbsr_top cbsr_top_asserts u_chk (
  .core_clk(core_clk), .reset(reset), .smb_clk_in(smb_clk_in), .smb_data_in(smb_data_in),
  .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe), .addr_sel_low(addr_sel_low),
  .addr_sel_high(addr_sel_high), .out4_enable_n(out4_enable_n), .out4_drive(out4_drive),
  .swing_sel(swing_sel), .edge_speed(edge_speed)
);

/* File: dv/cbsr_host_model.sv */
// SMBus host model: makes the bus clock and pulls the data wire low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps

module cbsr_host_model (
  // Bus clock, high and still outside frames.
  output logic scl,
  // Host pulls data low while this is high.
  output logic sda_low,
  // Resolved data wire.
  input  logic sda
);
  logic in_frame;  // High between start and stop.

  // Idle bus: clock high, data released.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    in_frame = 1'b0;
  end

  // One 125 ns bit slot: data moves mid-low, is sampled mid-high.
  task automatic xfer(input logic b, output logic v);
    begin
      scl = 1'b0;
      #31;
      sda_low = !b;
      #31;
      scl = 1'b1;
      #31;
      v = sda;
      #32;
    end
  endtask

  // Start, or repeated start inside a frame: data falls while clock high.
  task automatic start;
    begin
      if (in_frame) begin
        xfer(1'b1, in_frame);
      end
      sda_low = 1'b1;
      in_frame = 1'b1;
      #62;
    end
  endtask

  // Stop: data rises while clock high, then the bus idles.
  task automatic stop;
    logic v;
    begin
      xfer(1'b0, v);
      sda_low = 1'b0;
      in_frame = 1'b0;
      #62;
    end
  endtask

  // Sends a byte MSB first and reads the device acknowledge.
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic v;
    begin
      for (int i = 7; i >= 0; i--) xfer(b[i], v);
      xfer(1'b1, v);
      ack = !v;
    end
  endtask

  // Reads a byte, acknowledging all but the final one.
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic v;
    begin
      for (int i = 7; i >= 0; i--) begin
        xfer(1'b1, v);
        b[i] = v;
      end
      xfer(last, v);
    end
  endtask
endmodule // cbsr_host_model

/* File: dv/tb_clock_buffer_smbus_config_regs.sv */
// Self-checking bench of the configuration bank behind its SMBus pins.
// Assumes the design, the host model and the checker bind are compiled first.
`timescale 1ns/1ps

module tb_clock_buffer_smbus_config_regs;
  // ==========================================================================
  // Identity values, all arbitrary.
  localparam logic [3:0] REV = 4'h6;   // Arbitrary value.
  localparam logic [3:0] MAK = 4'hc;   // Arbitrary value.
  localparam logic [1:0] CLS = 2'h2;   // Arbitrary value.
  localparam logic [5:0] PRT = 6'h1b;  // Arbitrary value.

  logic       core_clk = 1'b0;   // Core clock.
  logic       reset = 1'b1;      // Synchronous reset.
  logic       sel_low = 1'b0;    // Address pin reads low.
  logic       sel_high = 1'b0;   // Address pin reads high.
  logic       pin_n = 1'b0;      // Output 4 enable pin.
  logic       scl, host_low, oe, dout, drive, a;
  wire        sda = !(host_low || (oe && !dout));  // Pulled-up data wire.
  logic [1:0] swing;
  logic [4:0] edge_spd;
  logic [6:0] addr;              // Current slave address.
  logic [7:0] ereg [0:7];        // Expected register image.
  logic [7:0] wdat [0:3];        // Data of the next block write.
  logic [7:0] cnts [0:2] = '{8'hff, 8'h00, 8'he5};
  int         num_errors = 0;
  int         samples_checked = 0;

  always #4 core_clk = !core_clk;

  cbsr_top #(.SILICON_REV(REV), .MAKER_CODE(MAK), .PART_CLASS(CLS), .PART_NUMBER(PRT)) u_dut (
    .core_clk(core_clk), .reset(reset), .smb_clk_in(scl), .smb_data_in(sda), .smb_data_out(dout),
    .smb_data_oe(oe), .addr_sel_low(sel_low), .addr_sel_high(sel_high), .out4_enable_n(pin_n),
    .out4_drive(drive), .swing_sel(swing), .edge_speed(edge_spd));
  cbsr_host_model u_host (.scl(scl), .sda_low(host_low), .sda(sda));

  // ==========================================================================
  // Checking helpers.
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Writable bits of each byte.
  function automatic logic [7:0] wmask(input logic [7:0] i);
    case (i)
      8'h01: return 8'h23;
      8'h02: return 8'h6a;
      8'h03: return 8'h01;
      8'h07: return 8'h1f;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] eread(input logic [7:0] i);
    return (i < 8'h08) ? ereg[i[2:0]] : 8'h00;
  endfunction

  // Block write of wdat; reserved and read-only bits keep their value.
  task automatic blk_write(input logic [7:0] idx, input logic [7:0] n);
    logic [7:0] j;
    u_host.start();
    u_host.wr_byte({addr, 1'b0}, a);
    check({7'h0, a}, 8'h01);
    u_host.wr_byte(idx, a);
    u_host.wr_byte(n, a);
    for (int i = 0; i < int'(n); i++) begin
      j = idx + 8'(i);
      u_host.wr_byte(wdat[i], a);
      check({7'h0, a}, 8'h01);
      if (j < 8'h08) ereg[j[2:0]] = (ereg[j[2:0]] & ~wmask(j)) | (wdat[i] & wmask(j));
    end
    u_host.stop();
  endtask

  // Block read: count first, then that many bytes from idx.
  task automatic blk_read(input logic [7:0] idx);
    logic [7:0] v;
    logic [7:0] n;
    n = {3'h0, ereg[7][4:0]};
    u_host.start();
    u_host.wr_byte({addr, 1'b0}, a);
    u_host.wr_byte(idx, a);
    u_host.start();
    u_host.wr_byte({addr, 1'b1}, a);
    check({7'h0, a}, 8'h01);
    u_host.rd_byte(n == 8'h00, v);
    check(v, n);
    for (int i = 0; i < int'(n); i++) begin
      u_host.rd_byte(i == int'(n) - 1, v);
      check(v, eread(idx + 8'(i)));
    end
    u_host.stop();
  endtask

  // Output stage controls against the expected image.
  task automatic chk_out;
    repeat (6) @(posedge core_clk);
    check({6'h0, swing}, {6'h0, ereg[1][1:0]});
    check({3'h0, edge_spd}, {3'h0, ereg[3][0], ereg[2][6], ereg[2][5], ereg[2][3], ereg[2][1]});
    check({7'h0, drive}, {7'h0, ereg[1][5] & !pin_n});
  endtask

  // Reset with a chosen address pin level; defaults come back.
  task automatic do_reset(input int s);
    @(posedge core_clk);
    #1;
    reset = 1'b1;
    sel_low = (s == 0);
    sel_high = (s == 2);
    addr = 7'h6b + 7'(s);
    ereg = '{8'h00, 8'h6c, 8'hff, 8'h01, 8'hff, {REV, MAK}, {CLS, PRT}, 8'h08};
    repeat (10) @(posedge core_clk);
    #1;
    reset = 1'b0;
    repeat (12) @(posedge core_clk);
  endtask

  // ==========================================================================
  // Main sequence: two reset rounds, corners, then random traffic.
  initial begin
    void'($urandom(33));
    for (int r = 0; r < 2; r++) begin
      do_reset($urandom_range(0, 2));
      chk_out();
      blk_read(8'h00);
      u_host.start();
      u_host.wr_byte({addr ^ 7'h01, 1'b0}, a);
      check({7'h0, a}, 8'h00);
      u_host.stop();
      for (int c = 0; c < 3; c++) begin
        wdat[0] = cnts[c];
        blk_write(8'h07, 8'h01);
        blk_read(8'h01);
      end
      for (int k = 0; k < 6; k++) begin
        for (int j = 0; j < 4; j++) wdat[j] = 8'($urandom);
        @(posedge core_clk);
        #1;
        pin_n = 1'($urandom);
        blk_write(8'($urandom_range(0, 8)), 8'($urandom_range(1, 4)));
        chk_out();
        blk_read(8'($urandom_range(1, 7)));
      end
    end
    close_out();
  end

  // Watchdog: two rounds of worst-case traffic take about 746 us, under 100k cycles.
  initial begin
    #780000;
    num_errors++;
    close_out();
  end
endmodule // tb_clock_buffer_smbus_config_regs
